// ==== verilog/sblx_pkg.sv ====
/*
 sixteen-bit load group execution package: opcodes, pair codes, machine cycle and state counts.
 assumes a one-cycle-per-clock-state timing model.
*/
package sblx_pkg;
   // =====================================================
   // opcode bytes
   localparam logic [7:0] SBLX_PFX_X = 8'hDD;
   localparam logic [7:0] SBLX_PFX_Y = 8'hFD;
   localparam logic [7:0] SBLX_PFX_E = 8'hED;
   localparam logic [7:0] SBLX_OP_IMM_IDX = 8'h21;
   localparam logic [7:0] SBLX_OP_LD_DIR = 8'h2A;
   localparam logic [7:0] SBLX_OP_ST_DIR = 8'h22;
   localparam logic [3:0] SBLX_LO_IMM = 4'h1;
   localparam logic [3:0] SBLX_LO_EDLD = 4'hB;
   localparam logic [3:0] SBLX_LO_EDST = 4'h3;
   // =====================================================
   // pair field codes
   localparam logic [1:0] SBLX_PAIR_FIRST = 2'h0;
   localparam logic [1:0] SBLX_PAIR_SECOND = 2'h1;
   localparam logic [1:0] SBLX_PAIR_THIRD = 2'h2;
   localparam logic [1:0] SBLX_PAIR_SP = 2'h3;
   // =====================================================
   // clock states per machine cycle
   localparam logic [2:0] SBLX_T_FETCH = 3'h4;
   localparam logic [2:0] SBLX_T_MEM = 3'h3;
   localparam logic [15:0] SBLX_RST_REG = 16'h0000;
   typedef enum logic [2:0] {
      SBLX_DST_FIRST = 3'b000,
      SBLX_DST_SECOND = 3'b001,
      SBLX_DST_THIRD = 3'b010,
      SBLX_DST_SP = 3'b011,
      SBLX_DST_X = 3'b100,
      SBLX_DST_Y = 3'b101
   } sblx_dst_t;
endpackage

// ==== verilog/sblx_tcnt.sv ====
/*
 clock-state counter of one machine cycle.
 assumes start pulses only when idle or on the last state.
*/
`timescale 1ns/100ps
module sblx_tcnt (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // control
   input wire logic start,
   input wire logic [2:0] len,
   output logic last
);
   import sblx_pkg::*;
   logic [2:0] cnt_ff;
   logic run_ff;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cnt_ff <= 3'h0;
         run_ff <= 1'b0;
      end else if (start) begin
         cnt_ff <= len - 3'h1;
         run_ff <= 1'b1;
      end else if (run_ff) begin
         if (cnt_ff == 3'h1) run_ff <= 1'b0;
         cnt_ff <= cnt_ff - 3'h1;
      end
   end

   assign last = run_ff && (cnt_ff == 3'h1);
endmodule

// ==== verilog/sblx_exec.sv ====
/*
 sixteen-bit load group: decodes opcode bytes and runs immediate and
 direct-address loads and stores, sequencing one byte per machine cycle.
 assumes memory answers a read with DIN valid on the last state of the cycle.
*/
// Function
// - pair field selects first, second, third, stack pointer
// - immediate pair load, low first, 10 states
// - DD 21 loads index x immediate, 14 states
// - index y immediate load, 14 states
// - direct load of third pair, 16 states
// - ED prefixed direct pair load, nn then nn+1
// - direct load of index x, 20 states
// - direct load of index y, 20 states
// - direct store of third pair, 16 states
// - ED prefixed direct pair store, 20 states
// - direct store of index x, 20 states
// - direct store of index y, 20 states
// - first address byte is low half
`timescale 1ns/100ps
module sblx_exec (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // memory bus
   input wire logic [7:0] DIN,
   output logic [15:0] ADDR,
   output logic [7:0] DOUT,
   output logic RD,
   output logic WR,
   // status
   output logic M1,
   output logic DONE,
   output logic ILLEGAL,
   // register file view
   output logic [15:0] PAIR_FIRST,
   output logic [15:0] PAIR_SECOND,
   output logic [15:0] PAIR_THIRD,
   output logic [15:0] STACK_PTR,
   output logic [15:0] INDEX_X,
   output logic [15:0] INDEX_Y
);
   import sblx_pkg::*;

   // =====================================================
   // sequencer
   typedef enum logic [2:0] {
      SBLX_S_OP1 = 3'b000,
      SBLX_S_OP2 = 3'b001,
      SBLX_S_NLO = 3'b010,
      SBLX_S_NHI = 3'b011,
      SBLX_S_DLO = 3'b100,
      SBLX_S_DHI = 3'b101
   } sblx_st_t;

   sblx_st_t st_ff;
   sblx_dst_t dst_ff;
   logic [15:0] pc_ff, opr_ff, regs_ff [6];
   logic [2:0] pfx_ff;
   logic store_ff, direct_ff, tstart_ff, tlast;
   logic [15:0] ADDR_ff;
   logic [7:0] DOUT_ff;
   logic RD_ff, WR_ff, M1_ff, DONE_ff, ILL_ff;
   logic [4:0] states_ff;

   sblx_tcnt u_tcnt (
      .CLK(CLK),
      .RST_B(RST_B),
      .start(tstart_ff),
      .len((st_ff == SBLX_S_OP1 || st_ff == SBLX_S_OP2) ? SBLX_T_FETCH : SBLX_T_MEM),
      .last(tlast)
   );

   function automatic sblx_dst_t pair_dst(input logic [1:0] f);
      pair_dst = sblx_dst_t'({1'b0, f});
   endfunction

   function automatic logic [15:0] inc16(input logic [15:0] a);
      inc16 = a + 16'h0001;
   endfunction

   wire logic [7:0] op = DIN;
   wire logic step = tlast;

   // =====================================================
   // decode and sequencing
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_ff <= SBLX_S_OP1;
         dst_ff <= SBLX_DST_FIRST;
         pfx_ff <= 3'h0;
         store_ff <= 1'b0;
         direct_ff <= 1'b0;
         pc_ff <= SBLX_RST_REG;
         opr_ff <= SBLX_RST_REG;
         ILL_ff <= 1'b0;
         DONE_ff <= 1'b0;
         tstart_ff <= 1'b1;
      end else begin
         DONE_ff <= 1'b0;
         ILL_ff <= 1'b0;
         tstart_ff <= step;
         if (step) begin
            pc_ff <= (st_ff == SBLX_S_DLO || st_ff == SBLX_S_DHI) ? pc_ff : inc16(pc_ff);
            unique case (st_ff)
               SBLX_S_OP1: begin
                  pfx_ff <= 3'h0;
                  if (op == SBLX_PFX_X || op == SBLX_PFX_Y || op == SBLX_PFX_E) begin
                     pfx_ff <= (op == SBLX_PFX_X) ? 3'h1 : (op == SBLX_PFX_Y) ? 3'h2 : 3'h4;
                     st_ff <= SBLX_S_OP2;
                  end else if (op[7:6] == 2'h0 && op[3:0] == SBLX_LO_IMM) begin
                     dst_ff <= pair_dst(op[5:4]);
                     store_ff <= 1'b0;
                     direct_ff <= 1'b0;
                     st_ff <= SBLX_S_NLO;
                  end else if (op == SBLX_OP_LD_DIR || op == SBLX_OP_ST_DIR) begin
                     dst_ff <= SBLX_DST_THIRD;
                     store_ff <= (op == SBLX_OP_ST_DIR);
                     direct_ff <= 1'b1;
                     st_ff <= SBLX_S_NLO;
                  end else begin
                     ILL_ff <= 1'b1;
                  end
               end
               SBLX_S_OP2: begin
                  st_ff <= SBLX_S_NLO;
                  if (pfx_ff[2] && op[7:6] == 2'h1 &&
                      (op[3:0] == SBLX_LO_EDLD || op[3:0] == SBLX_LO_EDST)) begin
                     dst_ff <= pair_dst(op[5:4]);
                     store_ff <= (op[3:0] == SBLX_LO_EDST);
                     direct_ff <= 1'b1;
                  end else if (!pfx_ff[2] && (op == SBLX_OP_IMM_IDX || op == SBLX_OP_LD_DIR ||
                              op == SBLX_OP_ST_DIR)) begin
                     dst_ff <= pfx_ff[1] ? SBLX_DST_Y : SBLX_DST_X;
                     store_ff <= (op == SBLX_OP_ST_DIR);
                     direct_ff <= (op != SBLX_OP_IMM_IDX);
                  end else begin
                     ILL_ff <= 1'b1;
                     st_ff <= SBLX_S_OP1;
                  end
               end
               SBLX_S_NLO: begin
                  opr_ff[7:0] <= DIN;
                  st_ff <= SBLX_S_NHI;
               end
               SBLX_S_NHI: begin
                  opr_ff[15:8] <= DIN;
                  st_ff <= direct_ff ? SBLX_S_DLO : SBLX_S_OP1;
                  DONE_ff <= !direct_ff;
               end
               SBLX_S_DLO: begin
                  st_ff <= SBLX_S_DHI;
               end
               SBLX_S_DHI: begin
                  st_ff <= SBLX_S_OP1;
                  DONE_ff <= 1'b1;
               end
            endcase
         end
      end
   end

   // =====================================================
   // register file writes, flags never touched
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = 0; i < 6; i++) regs_ff[i] <= SBLX_RST_REG;
      end else if (step) begin
         if (st_ff == SBLX_S_NHI && !direct_ff)
            regs_ff[dst_ff] <= {DIN, opr_ff[7:0]};
         else if (st_ff == SBLX_S_DLO && !store_ff)
            regs_ff[dst_ff][7:0] <= DIN;
         else if (st_ff == SBLX_S_DHI && !store_ff)
            regs_ff[dst_ff][15:8] <= DIN;
      end
   end

   // =====================================================
   // bus outputs, registered
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ADDR_ff <= SBLX_RST_REG;
         DOUT_ff <= 8'h00;
         RD_ff <= 1'b0;
         WR_ff <= 1'b0;
         M1_ff <= 1'b0;
      end else begin
         unique case (st_ff)
            SBLX_S_DLO: begin
               ADDR_ff <= opr_ff;
               DOUT_ff <= regs_ff[dst_ff][7:0];
            end
            SBLX_S_DHI: begin
               ADDR_ff <= inc16(opr_ff);
               DOUT_ff <= regs_ff[dst_ff][15:8];
            end
            default: begin
               ADDR_ff <= pc_ff;
               DOUT_ff <= 8'h00;
            end
         endcase
         RD_ff <= !((st_ff == SBLX_S_DLO || st_ff == SBLX_S_DHI) && store_ff);
         WR_ff <= (st_ff == SBLX_S_DLO || st_ff == SBLX_S_DHI) && store_ff;
         M1_ff <= (st_ff == SBLX_S_OP1 || st_ff == SBLX_S_OP2);
      end
   end

   // state counter for checking totals
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) states_ff <= 5'h0;
      else if (DONE_ff || ILL_ff) states_ff <= 5'h1;
      else states_ff <= states_ff + 5'h1;
   end

   assign ADDR = ADDR_ff;
   assign DOUT = DOUT_ff;
   assign RD = RD_ff;
   assign WR = WR_ff;
   assign M1 = M1_ff;
   assign DONE = DONE_ff;
   assign ILLEGAL = ILL_ff;
   assign PAIR_FIRST = regs_ff[0];
   assign PAIR_SECOND = regs_ff[1];
   assign PAIR_THIRD = regs_ff[2];
   assign STACK_PTR = regs_ff[3];
   assign INDEX_X = regs_ff[4];
   assign INDEX_Y = regs_ff[5];

   // =====================================================
   // checks
   wire logic sp_pick = (st_ff == SBLX_S_OP1) && step && op[7:6] == 2'h0 &&
                        op[3:0] == SBLX_LO_IMM;
   pair_decode_a: assert property (@(posedge CLK) disable iff (!RST_B)
      sp_pick |=> dst_ff == ($past(op[5:4]) == SBLX_PAIR_FIRST ? SBLX_DST_FIRST :
                             $past(op[5:4]) == SBLX_PAIR_SECOND ? SBLX_DST_SECOND :
                             $past(op[5:4]) == SBLX_PAIR_THIRD ? SBLX_DST_THIRD :
                             SBLX_DST_SP))
      else $error("pair field decoded wrongly");
   imm_pair_time_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (DONE && !$past(direct_ff) && $past(pfx_ff) == 3'h0 && $past(st_ff) == SBLX_S_NHI)
      |-> states_ff == 5'd10)
      else $error("immediate pair load not 10 states");
   imm_idx_time_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (DONE && !$past(direct_ff) && $past(pfx_ff) != 3'h0) |-> states_ff == 5'd14)
      else $error("immediate index load not 14 states");
   imm_low_first_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (step && st_ff == SBLX_S_NHI && !direct_ff) |=> regs_ff[dst_ff][7:0] == opr_ff[7:0])
      else $error("immediate low byte lost");
   dir_third_time_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (DONE && $past(direct_ff) && $past(pfx_ff) == 3'h0) |-> states_ff == 5'd16)
      else $error("unprefixed direct not 16 states");
   dir_pfx_time_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (DONE && $past(direct_ff) && $past(pfx_ff) != 3'h0) |-> states_ff == 5'd20)
      else $error("prefixed direct not 20 states");
   store_wrap_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (WR && $past(st_ff) == SBLX_S_DHI) |-> ADDR == $past(opr_ff) + 16'h0001)
      else $error("second address not nn+1");
   store_data_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (WR && $past(st_ff) == SBLX_S_DLO) |-> DOUT == $past(regs_ff[dst_ff][7:0]))
      else $error("low byte not stored first");
endmodule

// ==== verif/sblx_mem.sv ====
/*
 memory model on the far side of the load group bus.
 assumes ADDR, RD, WR and DOUT stand for a whole machine cycle.
*/
`timescale 1ns/100ps
module sblx_mem (
   // clock
   input wire logic CLK,
   // memory bus
   input wire logic [15:0] ADDR,
   input wire logic [7:0] DOUT,
   input wire logic RD,
   input wire logic WR,
   output logic [7:0] DIN
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_ff = 8'ha5;
   // ==========
   // released bus shows inverse of last byte
   assign DIN = RD ? mem[ADDR] : ~last_ff;
   // plain always: the bench preloads mem through the hierarchy
   always @(posedge CLK) begin
      if (RD) begin
         last_ff <= mem[ADDR];
      end
      if (WR) begin
         mem[ADDR] <= DOUT;
      end
   end
endmodule

// ==== verif/tb_top.sv ====
/*
 bench for the sixteen-bit load group: builds a program, models it, compares.
 assumes sblx_mem answers reads within the same machine cycle.
*/
`timescale 1ns/100ps
module tb_top;
   import sblx_pkg::*;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   logic [7:0] DIN;
   logic [15:0] ADDR;
   logic [7:0] DOUT;
   logic RD, WR, M1, DONE, ILLEGAL;
   logic [15:0] rg_o [6];
   int mm [65536];
   int rg [6];
   int eq_st[$];
   int eq_rg[$];
   int eq_m1[$];
   int pc, gap, cyc, exp_st, v, nbad, err_total, check_count, m1n, ill_n;
   integer seed;
   bit seen, fin;
   // ==========
   // clock, design and memory
   initial forever #12.5 CLK = ~CLK;
   sblx_exec u_dut (.CLK(CLK), .RST_B(RST_B), .DIN(DIN), .ADDR(ADDR), .DOUT(DOUT),
      .RD(RD), .WR(WR), .M1(M1), .DONE(DONE), .ILLEGAL(ILLEGAL), .PAIR_FIRST(rg_o[0]),
      .PAIR_SECOND(rg_o[1]), .PAIR_THIRD(rg_o[2]), .STACK_PTR(rg_o[3]),
      .INDEX_X(rg_o[4]), .INDEX_Y(rg_o[5]));
   sblx_mem u_mem (.CLK(CLK), .ADDR(ADDR), .DOUT(DOUT), .RD(RD), .WR(WR), .DIN(DIN));
   // ==========
   // checks and verdict
   task automatic chk(input bit ok, input string m);
      check_count++;
      if (!ok) begin
         err_total++;
         $display("Error %0t: %s", $time, m);
      end
   endtask
   task automatic tally_and_finish;
      if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========
   // program builder and reference model
   task automatic emit(input int b);
      mm[pc] = b & 255;
      u_mem.mem[pc] = b[7:0];
      pc++;
   endtask
   // k: 0 load, 1 store, 2 immediate; r 0..3 pairs, 4 x, 5 y
   task automatic op(input int k, input int r, input int ed, input int nn);
      int t;
      int m;
      t = 20;
      m = 8;
      if (r > 3) emit(r == 4 ? SBLX_PFX_X : SBLX_PFX_Y);
      else if (ed) emit(SBLX_PFX_E);
      else begin
         t = 16;
         m = 4;
      end
      if (k == 2) begin
         t = (r > 3) ? 14 : 10;
         emit(r > 3 ? SBLX_OP_IMM_IDX : {2'b00, r[1:0], SBLX_LO_IMM});
      end else if (r > 3 || !ed) emit(k ? SBLX_OP_ST_DIR : SBLX_OP_LD_DIR);
      else emit({2'b01, r[1:0], k ? SBLX_LO_EDST : SBLX_LO_EDLD});
      emit(nn);
      emit(nn >> 8);
      if (k == 2) rg[r] = nn;
      else if (k == 0) rg[r] = mm[nn] | mm[(nn + 1) & 'hffff] << 8;
      else begin
         mm[nn] = rg[r] & 255;
         mm[(nn + 1) & 'hffff] = (rg[r] >> 8) & 255;
      end
      eq_st.push_back(t);
      eq_m1.push_back(m);
      for (int i = 0; i < 6; i++) eq_rg.push_back(rg[i]);
   endtask
   // ==========
   // result monitor and timeout
   always @(negedge CLK) begin
      gap++;
      cyc++;
      if (M1 === 1'b1) m1n++;
      if (RST_B && DONE === 1'b1 && eq_st.size() > 0) begin
         exp_st = eq_st.pop_front();
         if (seen) chk(gap == exp_st, "state count");
         exp_st = eq_m1.pop_front();
         chk(m1n == exp_st, "opcode fetch cycles");
         m1n = 0;
         for (int i = 0; i < 6; i++) begin
            v = eq_rg.pop_front();
            chk(rg_o[i] === v[15:0], "register value");
         end
         seen = 1;
         gap = 0;
      end
      if (RST_B && ILLEGAL === 1'b1 && !fin) begin
         chk(eq_st.size() == 0, "unknown opcode flagged early");
         ill_n++;
         fin = (ill_n == 2);
      end
      if (cyc > 2000) begin
         chk(0, "timeout");
         tally_and_finish();
      end
   end
   // ==========
   // main sequence
   initial begin
      seed = 32'hb7bb_77c6;
      for (int a = 0; a < 65536; a++) begin
         mm[a] = $random(seed) & 255;
         u_mem.mem[a] = mm[a][7:0];
      end
      op(2, 0, 0, 'h1234);
      op(0, 1, 1, 'hffff);
      for (int r = 0; r < 6; r++) op(2, r, 0, $random(seed) & 'hffff);
      for (int k = 0; k < 2; k++) begin
         for (int r = 0; r < 7; r++) op(k, r == 6 ? 2 : r, r != 6, 'h8000 | $random(seed) & 'h7ffe);
      end
      op(1, 4, 0, 'hffff);
      // refused second byte after a prefix, then a refused single byte
      emit(SBLX_PFX_X);
      emit(8'h00);
      emit(8'h76);
      repeat (10) @(posedge CLK);
      chk({ADDR, RD, WR, DONE} === '0, "outputs during reset");
      repeat (10) @(posedge CLK);
      RST_B <= 1'b1;
      wait (fin);
      for (int i = 0; i < 6; i++) chk(rg_o[i] === rg[i][15:0], "register after refused opcode");
      nbad = 0;
      for (int a = 0; a < 65536; a++) if (u_mem.mem[a] !== mm[a][7:0]) nbad++;
      chk(nbad == 0, "memory image");
      tally_and_finish();
   end
endmodule
